// ===== rtl/dtc_pkg.sv
// Purpose: Shared constants and types for the dual timer/event counter
// Assumes: Wishbone classic slave, 32-bit data, byte registers in low bits
// Notes:   Register offsets are byte addresses of aligned words
package dtc_pkg;

    localparam logic [7:0] ADR_C8_VALUE   = 8'h00;
    localparam logic [7:0] ADR_C8_CTRL    = 8'h04;
    localparam logic [7:0] ADR_C16_LOW    = 8'h08;
    localparam logic [7:0] ADR_C16_HIGH   = 8'h0C;
    localparam logic [7:0] ADR_C16_CTRL   = 8'h10;
    localparam logic [7:0] ADR_INT_CTRL   = 8'h14;
    localparam logic [7:0] ADR_STATUS     = 8'h18;

    localparam int MODE_HI   = 7;
    localparam int MODE_LO   = 6;
    localparam int CSRC_BIT  = 5;
    localparam int RUN_BIT   = 4;
    localparam int EDGE_BIT  = 3;
    localparam int PSC_HI    = 2;
    localparam int PSC_LO    = 0;

    localparam logic [7:0] C8_CTRL_RESET  = 8'h08;
    localparam logic [7:0] C16_CTRL_RESET = 8'h08;
    localparam logic [7:0] C8_CTRL_MASK   = 8'hDF;
    localparam logic [7:0] C16_CTRL_MASK  = 8'hF8;
    localparam logic [7:0] INT_CTRL_MASK  = 8'h03;

    localparam logic [1:0] SYS_DIV4_TERM  = 2'h3;

    typedef enum logic [1:0] {
        DTC_MODE_CMP_EVENT = 2'b00,
        DTC_MODE_PIN_EVENT = 2'b01,
        DTC_MODE_TIMER     = 2'b10,
        DTC_MODE_PULSE     = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic       run;
        dtc_mode_t  mode;
        logic       edge_fall;
    } dtc_cfg_t;

    typedef struct packed {
        logic tick;
        logic pin_rise;
        logic pin_fall;
        logic cmp_rise;
        logic cmp_fall;
        logic pin_level;
    } dtc_evt_t;

endpackage

// ===== rtl/dtc_channel.sv
// Purpose: One up counter with preload, reload and mode-driven clocking
// Assumes: Events and tick are single-cycle pulses on clk_i
// Notes:   Width is a parameter; stop_o pulses when pulse capture ends
`timescale 1ns/1ps
module dtc_channel #(
    parameter int W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire dtc_pkg::dtc_cfg_t cfg_i,
    input  wire dtc_pkg::dtc_evt_t evt_i,
    input  wire logic              load_i,
    input  wire logic [W-1:0]      load_val_i,
    output logic [W-1:0]           count_o,
    output logic                   ovf_o,
    output logic                   stop_o
);

    logic [W-1:0] preload;
    logic         armed;
    logic         in_pulse;

    wire edge_sel  = cfg_i.edge_fall;
    wire pin_start = edge_sel ? evt_i.pin_rise : evt_i.pin_fall;
    wire pin_end   = edge_sel ? evt_i.pin_fall : evt_i.pin_rise;
    wire pin_cnt   = edge_sel ? evt_i.pin_fall : evt_i.pin_rise;
    wire cmp_cnt   = edge_sel ? evt_i.cmp_fall : evt_i.cmp_rise;

    wire pulse_md  = (cfg_i.mode == dtc_pkg::DTC_MODE_PULSE);
    wire step_raw  = (cfg_i.mode == dtc_pkg::DTC_MODE_TIMER)     ? evt_i.tick :
                     (cfg_i.mode == dtc_pkg::DTC_MODE_PIN_EVENT) ? pin_cnt :
                     (cfg_i.mode == dtc_pkg::DTC_MODE_CMP_EVENT) ? cmp_cnt :
                     (in_pulse & evt_i.tick);
    wire step      = cfg_i.run & step_raw;
    wire full      = (count_o == {W{1'b1}});
    wire wrap      = step & full;
    wire pulse_end = cfg_i.run & pulse_md & in_pulse & pin_end;

    assign armed = cfg_i.run & pulse_md & ~in_pulse & pin_start;

    // Preload has no reset: power-on contents are undefined by design
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            preload <= load_val_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o  <= '0;
            ovf_o    <= 1'b0;
            stop_o   <= 1'b0;
            in_pulse <= 1'b0;
        end else begin
            ovf_o  <= wrap;
            stop_o <= pulse_end;
            if (!cfg_i.run || !pulse_md) begin
                in_pulse <= 1'b0;
            end else if (armed) begin
                in_pulse <= 1'b1;
            end else if (pulse_end) begin
                in_pulse <= 1'b0;
            end
            if (load_i && !cfg_i.run) begin
                count_o <= load_val_i;
            end else if (wrap) begin
                count_o <= preload;
            end else if (step) begin
                count_o <= count_o + 1'b1;
            end
        end
    end

endmodule

// ===== rtl/dtc_top.sv
// Purpose: Dual timer/event counter, 8-bit and 16-bit, Wishbone slave
// Assumes: Single clock clk_i at 10 MHz; pins and comparators are asynchronous
// Notes:   Wake-up pulses on any overflow, independent of interrupt enables
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dtc_top #(
    parameter int PSC_W = 7
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        counter8_event_pin_i,
    input  wire logic        counter16_event_pin_i,
    input  wire logic        comparator_one_output_i,
    input  wire logic        comparator_two_output_i,
    input  wire logic        sub_clock_i,
    output logic             c8_irq_o,
    output logic             c16_irq_o,
    output logic             wakeup_o,
    output logic             c8_ovf_o,
    output logic             c16_ovf_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection
    localparam int NSYN = 5;

    wire  [NSYN-1:0] async_in = {sub_clock_i, comparator_two_output_i,
                                 comparator_one_output_i, counter16_event_pin_i,
                                 counter8_event_pin_i};
    logic [NSYN-1:0] sync_a;
    logic [NSYN-1:0] sync_b;
    logic [NSYN-1:0] sync_d;

    // Edge detectors read only the second stage and its delayed copy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_d <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    wire [NSYN-1:0] rise = sync_b & ~sync_d;
    wire [NSYN-1:0] fall = ~sync_b & sync_d;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  c8_ctrl;
    logic [7:0]  c16_ctrl;
    logic [7:0]  int_ctrl;
    logic [7:0]  low_buf;
    logic [7:0]  low_latch;
    logic [7:0]  c8_count;
    logic [15:0] c16_count;
    logic        c8_ovf;
    logic        c16_ovf;
    logic        c8_stop;
    logic        c16_stop;
    logic [1:0]  ovf_seen;

    wire req     = cyc_i & stb_i & ~ack_o;
    wire wr      = req & we_i & sel_i[0];
    wire rd      = req & ~we_i;
    wire wr_c8v  = wr & (adr_i == dtc_pkg::ADR_C8_VALUE);
    wire wr_c8c  = wr & (adr_i == dtc_pkg::ADR_C8_CTRL);
    wire wr_c16l = wr & (adr_i == dtc_pkg::ADR_C16_LOW);
    wire wr_c16h = wr & (adr_i == dtc_pkg::ADR_C16_HIGH);
    wire wr_c16c = wr & (adr_i == dtc_pkg::ADR_C16_CTRL);
    wire wr_intc = wr & (adr_i == dtc_pkg::ADR_INT_CTRL);
    wire wr_stat = wr & (adr_i == dtc_pkg::ADR_STATUS);
    wire rd_c16h = rd & (adr_i == dtc_pkg::ADR_C16_HIGH);
    wire [7:0] wd = dat_i[7:0];

    // Status bits are sticky overflow flags, write one to clear; set wins
    wire [1:0] next_ovf_seen = {c16_ovf, c8_ovf} |
                               (ovf_seen & ~({2{wr_stat}} & wd[1:0]));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c8_ctrl  <= dtc_pkg::C8_CTRL_RESET;
            c16_ctrl <= dtc_pkg::C16_CTRL_RESET;
            int_ctrl <= '0;
            ovf_seen <= '0;
        end else begin
            ovf_seen <= next_ovf_seen;
            if (wr_c8c) begin
                c8_ctrl <= wd & dtc_pkg::C8_CTRL_MASK;
            end else if (c8_stop) begin
                c8_ctrl[dtc_pkg::RUN_BIT] <= 1'b0;
            end
            if (wr_c16c) begin
                c16_ctrl <= wd & dtc_pkg::C16_CTRL_MASK;
            end else if (c16_stop) begin
                c16_ctrl[dtc_pkg::RUN_BIT] <= 1'b0;
            end
            if (wr_intc) begin
                int_ctrl <= wd & dtc_pkg::INT_CTRL_MASK;
            end
        end
    end

    // Holding buffers need no reset; low_buf is written and low_latch is filled by a C16 high read before use
    always_ff @(posedge clk_i) begin
        if (wr_c16l) begin
            low_buf <= wd;
        end
        if (rd_c16h) begin
            low_latch <= c16_count[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock sources
    logic [PSC_W-1:0] psc_cnt;
    logic [1:0]       div4_cnt;

    wire [2:0] psc_sel  = c8_ctrl[dtc_pkg::PSC_HI:dtc_pkg::PSC_LO];
    wire [PSC_W-1:0] psc_mask = PSC_W'((1 << psc_sel) - 1);
    wire c8_tick   = ((psc_cnt & psc_mask) == '0);
    wire div4_tick = (div4_cnt == dtc_pkg::SYS_DIV4_TERM);
    wire c16_tick  = c16_ctrl[dtc_pkg::CSRC_BIT] ? rise[4] : div4_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc_cnt  <= '0;
            div4_cnt <= '0;
        end else begin
            psc_cnt  <= psc_cnt + 1'b1;
            div4_cnt <= div4_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter channels
    dtc_pkg::dtc_cfg_t c8_cfg;
    dtc_pkg::dtc_cfg_t c16_cfg;
    dtc_pkg::dtc_evt_t c8_evt;
    dtc_pkg::dtc_evt_t c16_evt;

    assign c8_cfg  = '{run:       c8_ctrl[dtc_pkg::RUN_BIT],
                       mode:      dtc_pkg::dtc_mode_t'(c8_ctrl[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO]),
                       edge_fall: c8_ctrl[dtc_pkg::EDGE_BIT]};
    assign c16_cfg = '{run:       c16_ctrl[dtc_pkg::RUN_BIT],
                       mode:      dtc_pkg::dtc_mode_t'(c16_ctrl[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO]),
                       edge_fall: c16_ctrl[dtc_pkg::EDGE_BIT]};
    assign c8_evt  = '{tick: c8_tick, pin_rise: rise[0], pin_fall: fall[0],
                       cmp_rise: rise[2], cmp_fall: fall[2], pin_level: sync_b[0]};
    assign c16_evt = '{tick: c16_tick, pin_rise: rise[1], pin_fall: fall[1],
                       cmp_rise: rise[3], cmp_fall: fall[3], pin_level: sync_b[1]};

    dtc_channel #(.W(8)) u_c8 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cfg_i      (c8_cfg),
        .evt_i      (c8_evt),
        .load_i     (wr_c8v),
        .load_val_i (wd),
        .count_o    (c8_count),
        .ovf_o      (c8_ovf),
        .stop_o     (c8_stop)
    );

    dtc_channel #(.W(16)) u_c16 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cfg_i      (c16_cfg),
        .evt_i      (c16_evt),
        .load_i     (wr_c16h),
        .load_val_i ({wd, low_buf}),
        .count_o    (c16_count),
        .ovf_o      (c16_ovf),
        .stop_o     (c16_stop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and outputs
    wire [7:0] rd_byte =
        (adr_i == dtc_pkg::ADR_C8_VALUE) ? c8_count :
        (adr_i == dtc_pkg::ADR_C8_CTRL)  ? c8_ctrl :
        (adr_i == dtc_pkg::ADR_C16_LOW)  ? low_latch :
        (adr_i == dtc_pkg::ADR_C16_HIGH) ? c16_count[15:8] :
        (adr_i == dtc_pkg::ADR_C16_CTRL) ? c16_ctrl :
        (adr_i == dtc_pkg::ADR_INT_CTRL) ? int_ctrl :
        (adr_i == dtc_pkg::ADR_STATUS)   ? {6'h00, ovf_seen} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o     <= 1'b0;
            dat_o     <= '0;
            c8_irq_o  <= 1'b0;
            c16_irq_o <= 1'b0;
            wakeup_o  <= 1'b0;
            c8_ovf_o  <= 1'b0;
            c16_ovf_o <= 1'b0;
        end else begin
            ack_o     <= req;
            dat_o     <= rd ? {24'h000000, rd_byte} : 32'h00000000;
            c8_irq_o  <= c8_ovf & int_ctrl[0];
            c16_irq_o <= c16_ovf & int_ctrl[1];
            wakeup_o  <= c8_ovf | c16_ovf;
            c8_ovf_o  <= c8_ovf;
            c16_ovf_o <= c16_ovf;
        end
    end

endmodule

// ===== tb/dtc_top_props.sv
// Purpose: Port-level checks for the dual timer/event counter
// Assumes: Interrupt enables are shadowed from bus writes seen at the ports
// Notes:   Irq and wakeup may lag the raw overflow by one cycle
`timescale 1ns/1ps
module dtc_top_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        c8_irq_o,
    input wire logic        c16_irq_o,
    input wire logic        wakeup_o,
    input wire logic        c8_ovf_o,
    input wire logic        c16_ovf_o
);
    logic [1:0] ien;
    logic       we_q;
    wire        take = cyc_i && stb_i && !ack_o;
    // Registered direction: ack answers the request of the cycle before
    wire        rd_done = ack_o && !we_q;
    always_ff @(posedge clk_i) begin
        we_q <= we_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien <= 2'h0;
        end else if (take && we_i && sel_i[0] && adr_i == dtc_pkg::ADR_INT_CTRL) begin
            ien <= dat_i[1:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (take |=> ack_o) else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not idle");
    dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data set");
    irq8_gate_a: assert property (c8_irq_o |-> (ien[0] || $past(ien[0]))
        && (c8_ovf_o || $past(c8_ovf_o))) else $error("c8 irq ungated");
    irq16_gate_a: assert property (c16_irq_o |-> (ien[1] || $past(ien[1]))
        && (c16_ovf_o || $past(c16_ovf_o))) else $error("c16 irq ungated");
    wake_source_a: assert property (wakeup_o |-> c8_ovf_o || c16_ovf_o
        || $past(c8_ovf_o) || $past(c16_ovf_o)) else $error("wake no ovf");
    unmapped_zero_a: assert property (rd_done && $past(adr_i) > dtc_pkg::ADR_STATUS
        |-> dat_o == 32'h0) else $error("unmapped read");
    c8_ctrl_rsv_a: assert property (rd_done && $past(adr_i) == dtc_pkg::ADR_C8_CTRL
        |-> !dat_o[5]) else $error("c8 bit5 set");
    c16_ctrl_rsv_a: assert property (rd_done && $past(adr_i) == dtc_pkg::ADR_C16_CTRL
        |-> dat_o[2:0] == 3'h0) else $error("c16 low bits set");
    c8_irq_c: cover property (c8_irq_o);
    c16_irq_c: cover property (c16_irq_o);
    masked_wake_c: cover property (wakeup_o && !c8_irq_o && !c16_irq_o);
endmodule
bind dtc_top dtc_top_props i_dtc_top_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .c8_irq_o(c8_irq_o), .c16_irq_o(c16_irq_o), .wakeup_o(wakeup_o),
    .c8_ovf_o(c8_ovf_o), .c16_ovf_o(c16_ovf_o));

// ===== tb/dtc_far.sv
// Purpose: Far side: comparator outputs, event pins and a free sub clock
// Assumes: line_o = {c16 pin, comparator two, c8 pin, comparator one}
// Notes:   Levels held at least 7 cycles so the 2-stage synchroniser sees each one
`timescale 1ns/1ps
module dtc_far (
    input  wire logic clk_i,
    output logic [3:0] line_o,
    output logic       sub_clock_o
);
    initial begin
        line_o = 4'h0;
        sub_clock_o = 1'b0;
    end
    // Odd half period keeps the sub clock out of phase with clk_i
    initial forever #1030 sub_clock_o = ~sub_clock_o;
    task drive(input int idx, input logic lvl);
        @(posedge clk_i);
        line_o[idx] <= lvl;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

// ===== tb/dtc_top_test.sv
// Purpose: Register-level tests of the dual timer/event counter
// Assumes: Wishbone answer exactly one cycle after the request is taken
// Notes:   Preload has no reset, so each counting test clears or loads it first
`timescale 1ns/1ps
module dtc_top_test;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [31:0] rv;
    logic [3:0]  line;
    logic        sub_clk;
    wire  [4:0]  ev;
    int          fail_count = 0;
    int          num_checks = 0;
    int          irq8_n = 0;
    int          n;
    int          n0;
    logic [7:0]  radr [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [7:0]  rexp [6] = '{8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};
    dtc_top i_dtc_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .counter8_event_pin_i(line[1]), .counter16_event_pin_i(line[3]),
        .comparator_one_output_i(line[0]), .comparator_two_output_i(line[2]),
        .sub_clock_i(sub_clk), .c8_irq_o(ev[0]), .c8_ovf_o(ev[1]), .c16_irq_o(ev[2]),
        .c16_ovf_o(ev[3]), .wakeup_o(ev[4]));
    dtc_far i_dtc_far (.clk_i(clk), .line_o(line), .sub_clock_o(sub_clk));
    ////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task timeout;
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        results();
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rv = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n >= 20) timeout();
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 32'h0);
        chk(rv, {24'h0, e});
    endtask
    task wait_ev(input int k, input int lim);
        for (n = 0; n < lim && ev[k] !== 1'b1; n++) @(negedge clk);
        if (n >= lim) timeout();
    endtask
    always @(posedge clk) if (ev[0] === 1'b1) irq8_n <= irq8_n + 1;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst, cyc, stb, we, adr, sel, wdat} = {4'b1000, 8'h00, 4'h0, 32'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (radr[i]) rd(radr[i], rexp[i]);
        $display("test reset values done");
        wr(dtc_pkg::ADR_C8_CTRL, 8'h07);
        wr(dtc_pkg::ADR_C8_VALUE, 8'hFE);
        rd(dtc_pkg::ADR_C8_VALUE, 8'hFE);
        wr(dtc_pkg::ADR_INT_CTRL, 8'h01);
        wr(dtc_pkg::ADR_C8_CTRL, 8'h97);
        wr(dtc_pkg::ADR_C8_VALUE, 8'h40);
        wb(1'b0, dtc_pkg::ADR_C8_VALUE, 32'h0);
        chk({rv[31:1], 1'b0}, 32'hFE);
        wait_ev(0, 400);
        rd(dtc_pkg::ADR_C8_VALUE, 8'h40);
        wr(dtc_pkg::ADR_INT_CTRL, 8'h00);
        n0 = irq8_n;
        // Preload FF: every prescaled tick is an overflow
        for (int p = 0; p < 4; p++) begin
            wr(dtc_pkg::ADR_C8_CTRL, 8'h07);
            wr(dtc_pkg::ADR_C8_VALUE, 8'hFF);
            wr(dtc_pkg::ADR_C8_CTRL, 8'h90 | p[7:0]);
            wait_ev(1, 300);
            chk({30'h0, ev[4], ev[0]}, 32'h2);
            @(negedge clk);
            wait_ev(1, 300);
            chk(n + 1, 32'h1 << p);
        end
        chk(irq8_n, n0);
        $display("test c8 timer done");
        for (int i = 0; i < 2; i++) begin
            wr(dtc_pkg::ADR_C8_CTRL, 8'h00);
            wr(dtc_pkg::ADR_C8_VALUE, 8'h00);
            wr(dtc_pkg::ADR_C8_CTRL, {i[1:0], 6'h17});
            i_dtc_far.drive(i, 1'b1);
            i_dtc_far.drive(i, 1'b0);
            i_dtc_far.drive(i, 1'b1);
            rd(dtc_pkg::ADR_C8_VALUE, 8'h02);
            i_dtc_far.drive(i, 1'b0);
        end
        wr(dtc_pkg::ADR_C8_CTRL, 8'h5F);
        i_dtc_far.drive(1, 1'b1);
        i_dtc_far.drive(1, 1'b0);
        rd(dtc_pkg::ADR_C8_VALUE, 8'h03);
        wr(dtc_pkg::ADR_C8_CTRL, 8'hD8);
        i_dtc_far.drive(1, 1'b1);
        i_dtc_far.drive(1, 1'b0);
        rd(dtc_pkg::ADR_C8_CTRL, 8'hC8);
        // High level held 7 cycles at divide-by-one: 3 plus 7 counts
        rd(dtc_pkg::ADR_C8_VALUE, 8'h0A);
        $display("test c8 events done");
        wr(dtc_pkg::ADR_C16_LOW, 8'h34);
        rd(dtc_pkg::ADR_C16_HIGH, 8'h00);
        rd(dtc_pkg::ADR_C16_LOW, 8'h00);
        wr(dtc_pkg::ADR_C16_HIGH, 8'h12);
        rd(dtc_pkg::ADR_C16_HIGH, 8'h12);
        rd(dtc_pkg::ADR_C16_LOW, 8'h34);
        wr(dtc_pkg::ADR_INT_CTRL, 8'h02);
        for (int s = 0; s < 2; s++) begin
            wr(dtc_pkg::ADR_C16_LOW, 8'hFE);
            wr(dtc_pkg::ADR_C16_HIGH, 8'hFF);
            wr(dtc_pkg::ADR_C16_CTRL, s ? 8'hB0 : 8'h90);
            wait_ev(2, 300);
            chk({29'h0, ev[4:2]}, 32'h7);
            wr(dtc_pkg::ADR_C16_CTRL, 8'h08);
            rd(dtc_pkg::ADR_C16_HIGH, 8'hFF);
        end
        wr(dtc_pkg::ADR_C16_LOW, 8'h00);
        wr(dtc_pkg::ADR_C16_HIGH, 8'h00);
        wr(dtc_pkg::ADR_C16_CTRL, 8'h10);
        repeat (2) begin
            i_dtc_far.drive(2, 1'b1);
            i_dtc_far.drive(2, 1'b0);
        end
        rd(dtc_pkg::ADR_C16_HIGH, 8'h00);
        rd(dtc_pkg::ADR_C16_LOW, 8'h02);
        // Both counters have overflowed; sticky flags clear on write of one
        rd(dtc_pkg::ADR_STATUS, 8'h03);
        wr(dtc_pkg::ADR_STATUS, 8'h03);
        rd(dtc_pkg::ADR_STATUS, 8'h00);
        $display("test c16 done");
        results();
    end
endmodule
